// [rtl/gatl_alert_logic.sv]
`timescale 1ns/10ps
`include "gatl_alert_regs.svh"
module gatl_alert_logic
  import gatl_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          arst_n,
  // decoded register port from the serial interface
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_rd,
  output logic [15:0]        reg_rdata_q,
  output logic               reg_rvalid_q,
  // measurement results, one-cycle update strobe
  input  wire logic          meas_valid,
  input  wire logic [15:0]   cell_voltage_reading,
  input  wire logic [15:0]   current_reading,
  input  wire logic [15:0]   thermistor_reading,
  input  wire logic [15:0]   die_reading,
  input  wire logic [15:0]   reported_charge_level,
  // analog battery-detect comparators (asynchronous)
  input  wire logic          removal_cmp,
  input  wire logic          insertion_cmp,
  // configuration levels
  input  wire logic          alert_enable,
  input  wire logic          removal_detect_enable,
  input  wire logic          insertion_detect_enable,
  input  wire logic          charge_step_alert_enable,
  input  wire logic          thermal_source_select,
  input  wire logic          threshold_sticky,
  // open-drain alert pin: data and active-low enable
  output logic               alert_output_q,
  output logic               alert_output_oe_n_q
);

  // ************************************************************
  // storage
  // ************************************************************
  gatl_word_type vlim_q;       // voltage limit pair
  gatl_word_type tlim_q;       // thermal limit pair
  gatl_word_type slim_q;       // charge limit pair
  gatl_word_type ilim_q;       // current limit pair
  gatl_word_type text_q;       // thermal extremes
  gatl_word_type iext_q;       // current extremes
  gatl_word_type die_q;        // die thermal reading
  gatl_word_type pwr_q;        // instantaneous power
  gatl_word_type apwr_q;       // filtered power
  gatl_word_type flag_q;       // status flags
  gatl_word_type flag_d;       // next status flags
  logic [1:0]    rem_sync_q;   // removal comparator sync
  logic [1:0]    ins_sync_q;   // insertion comparator sync
  logic          soc_bit_q;    // last charge one-percent bit
  logic          primed_q;     // a charge sample has been seen

  // ************************************************************
  // write decode
  // ************************************************************
  logic wr_status;  // host write to status
  logic wr_text;    // host write to thermal extremes
  logic wr_iext;    // host write to current extremes
  assign wr_status = reg_wr && (reg_addr == `GATL_STATUS_OFS);
  assign wr_text   = reg_wr && (reg_addr == `GATL_TEXT_OFS);
  assign wr_iext   = reg_wr && (reg_addr == `GATL_IEXT_OFS);

  // ************************************************************
  // reading selection and comparisons
  // ************************************************************
  gatl_word_type temp_rd;  // main thermal reading
  logic v_hi, v_lo;        // voltage violations
  logic t_hi, t_lo;        // thermal violations
  logic s_hi, s_lo;        // charge violations
  logic i_hi, i_lo;        // current violations
  logic soc_step;          // charge one-percent bit moved
  assign temp_rd = thermal_source_select ? thermistor_reading
                                         : die_reading;

  assign v_hi = gatl_outside(cell_voltage_reading[15:8],
                             vlim_q[15:8], 8'h00, 1'b0);
  assign v_lo = gatl_outside(cell_voltage_reading[15:8],
                             8'hFF, vlim_q[7:0], 1'b0);
  assign t_hi = gatl_outside(temp_rd[15:8], tlim_q[15:8],
                             8'h80, 1'b1);
  assign t_lo = gatl_outside(temp_rd[15:8], 8'h7F,
                             tlim_q[7:0], 1'b1);
  assign s_hi = gatl_outside(reported_charge_level[15:8],
                             slim_q[15:8], 8'h00, 1'b0);
  assign s_lo = gatl_outside(reported_charge_level[15:8],
                             8'hFF, slim_q[7:0], 1'b0);
  assign i_hi = gatl_outside(current_reading[15:8],
                             ilim_q[15:8], 8'h80, 1'b1);
  assign i_lo = gatl_outside(current_reading[15:8], 8'h7F,
                             ilim_q[7:0], 1'b1);

  assign soc_step = meas_valid && primed_q &&
                    (reported_charge_level[8] != soc_bit_q);

  // ************************************************************
  // comparator synchronisers
  // ************************************************************
  // two flops each; only the second stage is looked at
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rem_sync_q <= 2'b00;
      ins_sync_q <= 2'b00;
    end else begin
      rem_sync_q <= {rem_sync_q[0], removal_cmp};
      ins_sync_q <= {ins_sync_q[0], insertion_cmp};
    end
  end

  // ************************************************************
  // charge bit history
  // ************************************************************
  // the first sample only primes, so power-up cannot fake a step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      soc_bit_q <= 1'b0;
      primed_q  <= 1'b0;
    end else if (meas_valid) begin
      soc_bit_q <= reported_charge_level[8];
      primed_q  <= 1'b1;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_comb begin
    gatl_word_type set_v;  // events this cycle
    gatl_word_type clr_v;  // clears this cycle
    set_v = 16'h0000;
    clr_v = 16'h0000;
    set_v[`GATL_BIT_BR] = rem_sync_q[1] && removal_detect_enable;
    set_v[`GATL_BIT_BI] = ins_sync_q[1] && insertion_detect_enable;
    if (meas_valid && alert_enable) begin
      set_v[`GATL_BIT_VMX] = v_hi;
      set_v[`GATL_BIT_VMN] = v_lo;
      set_v[`GATL_BIT_TMX] = t_hi;
      set_v[`GATL_BIT_TMN] = t_lo;
      set_v[`GATL_BIT_SMX] = s_hi;
      set_v[`GATL_BIT_SMN] = s_lo;
      set_v[`GATL_BIT_IMX] = i_hi;
      set_v[`GATL_BIT_IMN] = i_lo;
    end
    set_v[`GATL_BIT_DSOC] = soc_step && charge_step_alert_enable;
    if (wr_status) begin
      clr_v = ~reg_wdata;
    end
    if (meas_valid && !threshold_sticky) begin
      clr_v = clr_v | `GATL_THR_MASK;
    end
    // set beats clear when both land together
    flag_d = ((flag_q & ~clr_v) | set_v) & `GATL_STATUS_MASK;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 16'h0000;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ************************************************************
  // limit registers
  // ************************************************************
  // limit resets
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vlim_q <= `GATL_VLIM_RST;
      tlim_q <= `GATL_TLIM_RST;
      slim_q <= `GATL_SLIM_RST;
      ilim_q <= `GATL_ILIM_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `GATL_VLIM_OFS: vlim_q <= reg_wdata;
        `GATL_TLIM_OFS: tlim_q <= reg_wdata;
        `GATL_SLIM_OFS: slim_q <= reg_wdata;
        `GATL_ILIM_OFS: ilim_q <= reg_wdata;
        default: ;  // other offsets hold no limit
      endcase
    end
  end

  // ************************************************************
  // extremes tracking
  // ************************************************************
  // a host write wins over a same-cycle update
  // current extremes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      iext_q <= `GATL_EXT_RST;
    end else if (wr_iext) begin
      iext_q <= reg_wdata;
    end else if (meas_valid) begin
      if ($signed(current_reading[15:8]) > $signed(iext_q[15:8]))
        iext_q[15:8] <= current_reading[15:8];
      if ($signed(current_reading[15:8]) < $signed(iext_q[7:0]))
        iext_q[7:0] <= current_reading[15:8];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      text_q <= `GATL_EXT_RST;
    end else if (wr_text) begin
      text_q <= reg_wdata;
    end else if (meas_valid) begin
      if ($signed(temp_rd[15:8]) > $signed(text_q[15:8]))
        text_q[15:8] <= temp_rd[15:8];
      if ($signed(temp_rd[15:8]) < $signed(text_q[7:0]))
        text_q[7:0] <= temp_rd[15:8];
    end
  end

  // ************************************************************
  // die reading and power
  // ************************************************************
  logic signed [32:0] prod;   // current times voltage
  logic signed [16:0] pdiff;  // new power minus average
  logic signed [16:0] pstep;  // filter correction
  assign prod  = $signed(current_reading) *
                 $signed({1'b0, cell_voltage_reading});
  assign pdiff = $signed({pwr_q[15], pwr_q}) -
                 $signed({apwr_q[15], apwr_q});
  assign pstep = pdiff >>> `GATL_AVG_SHIFT;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      die_q <= 16'h0000;
      pwr_q <= 16'h0000;
    end else if (meas_valid) begin
      die_q <= die_reading;
      pwr_q <= prod[31:16];
    end
  end

  // first-order average
  // the filter lags one update behind the power word
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      apwr_q <= 16'h0000;
    end else if (meas_valid) begin
      apwr_q <= apwr_q + pstep[15:0];
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // unmapped offsets read as zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q  <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `GATL_STATUS_OFS: reg_rdata_q <= flag_q;
          `GATL_VLIM_OFS:   reg_rdata_q <= vlim_q;
          `GATL_TLIM_OFS:   reg_rdata_q <= tlim_q;
          `GATL_SLIM_OFS:   reg_rdata_q <= slim_q;
          `GATL_TEXT_OFS:   reg_rdata_q <= text_q;
          `GATL_IEXT_OFS:   reg_rdata_q <= iext_q;
          `GATL_DIE_OFS:    reg_rdata_q <= die_q;
          `GATL_PWR_OFS:    reg_rdata_q <= pwr_q;
          `GATL_APWR_OFS:   reg_rdata_q <= apwr_q;
          `GATL_ILIM_OFS:   reg_rdata_q <= ilim_q;
          default:          reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // ************************************************************
  // alert pin
  // ************************************************************
  // pin pulls low only; the board pull-up gives the high level
  // drive while any flag stands
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alert_output_q      <= 1'b0;
      alert_output_oe_n_q <= 1'b1;
    end else begin
      alert_output_q      <= 1'b0;
      alert_output_oe_n_q <= ~(|flag_q);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_alert_drive;
    @(posedge clock) disable iff (!arst_n)
      (|flag_q) |=> !alert_output_oe_n_q;
  endproperty
  a_alert_drive: assert property (p_alert_drive)
    else $error("alert not driven with flag set");

  property p_removal;
    @(posedge clock) disable iff (!arst_n)
      (rem_sync_q[1] && removal_detect_enable)
        |=> flag_q[`GATL_BIT_BR] ##1 !alert_output_oe_n_q;
  endproperty
  a_removal: assert property (p_removal)
    else $error("removal not flagged");

  property p_insertion;
    @(posedge clock) disable iff (!arst_n)
      $rose(ins_sync_q[1]) && insertion_detect_enable
        |=> flag_q[`GATL_BIT_BI];
  endproperty
  a_insertion: assert property (p_insertion)
    else $error("insertion not flagged");

  property p_aen_gate;
    @(posedge clock) disable iff (!arst_n)
      $rose(flag_q[`GATL_BIT_VMX]) |-> $past(alert_enable);
  endproperty
  a_aen_gate: assert property (p_aen_gate)
    else $error("limit flag set with alerts off");

  property p_soc_step;
    @(posedge clock) disable iff (!arst_n)
      (soc_step && charge_step_alert_enable)
        |=> flag_q[`GATL_BIT_DSOC];
  endproperty
  a_soc_step: assert property (p_soc_step)
    else $error("charge step not flagged");

  property p_removal_hold;
    @(posedge clock) disable iff (!arst_n)
      flag_q[`GATL_BIT_BR] &&
      !(wr_status && !reg_wdata[`GATL_BIT_BR])
        |=> flag_q[`GATL_BIT_BR];
  endproperty
  a_removal_hold: assert property (p_removal_hold)
    else $error("removal flag dropped without clear");

  property p_auto_clear;
    @(posedge clock) disable iff (!arst_n)
      (meas_valid && !threshold_sticky && !v_hi)
        |=> !flag_q[`GATL_BIT_VMX];
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("self-clearing flag stayed set");

  property p_volt_low;
    @(posedge clock) disable iff (!arst_n)
      (meas_valid && alert_enable && v_lo)
        |=> flag_q[`GATL_BIT_VMN] ##1 !alert_output_oe_n_q;
  endproperty
  a_volt_low: assert property (p_volt_low)
    else $error("low voltage not flagged");

  property p_iext_restart;
    @(posedge clock) disable iff (!arst_n)
      (wr_iext && reg_wdata == `GATL_EXT_RST)
        |=> iext_q == `GATL_EXT_RST;
  endproperty
  a_iext_restart: assert property (p_iext_restart)
    else $error("current extremes did not restart");

  property p_die;
    @(posedge clock) disable iff (!arst_n)
      meas_valid |=> die_q == $past(die_reading);
  endproperty
  a_die: assert property (p_die)
    else $error("die reading not captured");

endmodule // gatl_alert_logic

// [rtl/gatl_alert_regs.svh]
`ifndef GATL_ALERT_REGS_SVH
`define GATL_ALERT_REGS_SVH
// register offsets
`define GATL_STATUS_OFS   8'h00
`define GATL_VLIM_OFS     8'h01
`define GATL_TLIM_OFS     8'h02
`define GATL_SLIM_OFS     8'h03
`define GATL_TEXT_OFS     8'h1A
`define GATL_IEXT_OFS     8'h1C
`define GATL_DIE_OFS      8'h34
`define GATL_PWR_OFS      8'hB1
`define GATL_APWR_OFS     8'hB3
`define GATL_ILIM_OFS     8'hB4
// reset values
`define GATL_VLIM_RST     16'hFF00
`define GATL_TLIM_RST     16'h7F80
`define GATL_SLIM_RST     16'hFF00
`define GATL_ILIM_RST     16'h7F80
`define GATL_EXT_RST      16'h807F
// status field positions
`define GATL_BIT_BR       15
`define GATL_BIT_SMX      14
`define GATL_BIT_TMX      13
`define GATL_BIT_VMX      12
`define GATL_BIT_BI       11
`define GATL_BIT_SMN      10
`define GATL_BIT_TMN      9
`define GATL_BIT_VMN      8
`define GATL_BIT_DSOC     7
`define GATL_BIT_IMX      6
`define GATL_BIT_IMN      2
`define GATL_STATUS_MASK  16'hFFC4
`define GATL_THR_MASK     16'h7744
// averaging filter shift
`define GATL_AVG_SHIFT    4
`endif

// [rtl/gatl_pkg.sv]
package gatl_pkg;
  // one 16-bit register word
  typedef logic [15:0] gatl_word_type;
  // one 8-bit limit or tracking byte
  typedef logic [7:0]  gatl_byte_type;

  // true when a reading byte lies outside [lo, hi]
  function automatic logic gatl_outside(input gatl_byte_type rd,
                                        input gatl_byte_type hi,
                                        input gatl_byte_type lo,
                                        input logic          sgn);
    logic above;
    logic below;
    above = sgn ? ($signed(rd) > $signed(hi)) : (rd > hi);
    below = sgn ? ($signed(rd) < $signed(lo)) : (rd < lo);
    return above | below;
  endfunction
endpackage

// [dv/gatl_host_model.sv]
`timescale 1ns/10ps
// ****************************************
// host side of the decoded register port
// ****************************************
module gatl_host_model (
  input  wire logic        clock,
  output logic [7:0]       reg_addr,
  output logic             reg_wr,
  output logic [15:0]      reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata_q,
  input  wire logic        reg_rvalid_q
);
  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  // mapped offsets only
  // one write per call; data is inverted after release so stale data
  // can never pass for a fresh word
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // read strobe for one cycle, answer awaited a bounded time
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic ok);
    int n;
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    ok = 1'b0;
    d  = 16'h0000;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (reg_rvalid_q === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata_q;
      end else begin
        @(posedge clock);
      end
    end
  endtask
endmodule // gatl_host_model

// [dv/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import gatl_pkg::*;
  logic          clock, arst_n;
  logic [7:0]    reg_addr;
  logic          reg_wr, reg_rd, reg_rvalid_q, meas_valid;
  gatl_word_type reg_wdata, reg_rdata_q;
  gatl_word_type cell_voltage_reading, current_reading;
  gatl_word_type thermistor_reading, die_reading, reported_charge_level;
  logic          removal_cmp, insertion_cmp, alert_enable, threshold_sticky;
  logic          removal_detect_enable, insertion_detect_enable;
  logic          charge_step_alert_enable, thermal_source_select;
  logic          alert_output_q, alert_output_oe_n_q;
  int            num_errors = 0;
  int            n_checks = 0;
  gatl_word_type rdata;
  logic          ok;
  gatl_byte_type rv[4];
  // violating bytes per limit, upper then lower: volt, thermal, charge, current
  gatl_byte_type viol[8] = '{8'hA0, 8'h60, 8'h50, 8'hF6,
                             8'h70, 8'h05, 8'h30, 8'hD0};
  gatl_word_type bits[8] = '{16'h1000, 16'h0100, 16'h2000, 16'h0200,
                             16'h4000, 16'h0400, 16'h0040, 16'h0004};
  gatl_byte_type nom[4] = '{8'h80, 8'h19, 8'h32, 8'h00};

  // ****************************************
  // clock, design and host
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  gatl_alert_logic dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .meas_valid(meas_valid),
    .cell_voltage_reading(cell_voltage_reading),
    .current_reading(current_reading),
    .thermistor_reading(thermistor_reading), .die_reading(die_reading),
    .reported_charge_level(reported_charge_level),
    .removal_cmp(removal_cmp), .insertion_cmp(insertion_cmp),
    .alert_enable(alert_enable),
    .removal_detect_enable(removal_detect_enable),
    .insertion_detect_enable(insertion_detect_enable),
    .charge_step_alert_enable(charge_step_alert_enable),
    .thermal_source_select(thermal_source_select),
    .threshold_sticky(threshold_sticky), .alert_output_q(alert_output_q),
    .alert_output_oe_n_q(alert_output_oe_n_q));

  gatl_host_model host (
    .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q));

  // ****************************************
  // compare and report tasks
  // ****************************************
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_word(input gatl_word_type got, input gatl_word_type exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a missing answer ends the run at once
  task automatic rd_chk(input logic [7:0] a, input gatl_word_type exp);
    host.rd(a, rdata, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      stop_test();
    end else begin
      chk_word(rdata, exp);
    end
  endtask

  // pin is only ever pulled low; data stays 0
  task automatic pin(input logic exp_oe_n);
    chk_bit(alert_output_oe_n_q, exp_oe_n);
    chk_bit(alert_output_q, 1'b0);
  endtask

  // one measurement strobe, readings given as upper bytes
  task automatic meas(input gatl_byte_type v, input gatl_byte_type i,
                      input gatl_byte_type t, input gatl_byte_type s);
    @(posedge clock);
    cell_voltage_reading  <= {v, 8'h00};
    current_reading       <= {i, 8'h00};
    die_reading           <= {t, 8'h00};
    reported_charge_level <= {s, 8'h00};
    meas_valid            <= 1'b1;
    @(posedge clock);
    meas_valid <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {arst_n, meas_valid, removal_cmp, insertion_cmp, alert_enable} = '0;
    {removal_detect_enable, insertion_detect_enable} = '0;
    {charge_step_alert_enable, thermal_source_select} = '0;
    threshold_sticky = 1'b1;
    {cell_voltage_reading, current_reading, die_reading} = '0;
    reported_charge_level = 16'h0000;
    // thermistor far out of range; must be ignored while die is selected
    thermistor_reading = 16'h7000;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    pin(1'b1);
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h01, 16'hFF00);
    rd_chk(8'h02, 16'h7F80);
    rd_chk(8'h03, 16'hFF00);
    rd_chk(8'hB4, 16'h7F80);
    rd_chk(8'h1A, 16'h807F);
    rd_chk(8'h1C, 16'h807F);
    // power 0x4000 * 0x8000 keeps 0x2000 in the upper half
    meas(8'h80, 8'h40, 8'h19, 8'h32);
    rd_chk(8'hB1, 16'h2000);
    rd_chk(8'hB3, 16'h0000);
    meas(8'h80, 8'h40, 8'h19, 8'h32);
    rd_chk(8'hB3, 16'h0200);
    host.wr(8'h1A, 16'h807F);
    host.wr(8'h1C, 16'h807F);
    host.wr(8'h01, 16'h9070);
    host.wr(8'h02, 16'h3C00);
    host.wr(8'h03, 16'h6010);
    host.wr(8'hB4, 16'h20E0);
    @(posedge clock);
    alert_enable <= 1'b1;
    // every limit, upper and lower, sticky mode
    for (int k = 0; k < 8; k++) begin
      rv = nom;
      rv[k/2] = viol[k];
      meas(rv[0], rv[3], rv[1], rv[2]);
      @(posedge clock);
      #1;
      pin(1'b0);
      meas(nom[0], nom[3], nom[1], nom[2]);
      rd_chk(8'h00, bits[k]);
      host.wr(8'h00, 16'h0000);
      rd_chk(8'h00, 16'h0000);
      pin(1'b1);
    end
    rd_chk(8'h1A, 16'h50F6);
    rd_chk(8'h1C, 16'h30D0);
    host.wr(8'h34, 16'hABCD);
    rd_chk(8'h34, 16'h1900);
    rd_chk(8'h05, 16'h0000);
    // self-clearing mode, then alerts disabled
    threshold_sticky <= 1'b0;
    meas(8'hA0, nom[3], nom[1], nom[2]);
    rd_chk(8'h00, 16'h1000);
    meas(nom[0], nom[3], nom[1], nom[2]);
    rd_chk(8'h00, 16'h0000);
    alert_enable <= 1'b0;
    meas(8'hA0, nom[3], nom[1], nom[2]);
    rd_chk(8'h00, 16'h0000);
    // one-percent step flips bit 8 of the charge word
    charge_step_alert_enable <= 1'b1;
    meas(nom[0], nom[3], nom[1], 8'h33);
    rd_chk(8'h00, 16'h0080);
    host.wr(8'h00, 16'h0000);
    meas(nom[0], nom[3], nom[1], 8'h33);
    rd_chk(8'h00, 16'h0000);
    charge_step_alert_enable <= 1'b0;
    // thermistor selected: main thermal follows it, die word stays die
    thermal_source_select <= 1'b1;
    meas(nom[0], nom[3], nom[1], nom[2]);
    rd_chk(8'h1A, 16'h70F6);
    rd_chk(8'h34, 16'h1900);
    // removal then insertion; the flag outlives the comparator
    for (int j = 0; j < 2; j++) begin
      @(posedge clock);
      removal_detect_enable   <= (j == 0);
      removal_cmp             <= (j == 0);
      insertion_detect_enable <= (j == 1);
      insertion_cmp           <= (j == 1);
      repeat (6) @(posedge clock);
      rd_chk(8'h00, j ? 16'h0800 : 16'h8000);
      {removal_cmp, insertion_cmp} <= 2'b00;
      repeat (6) @(posedge clock);
      rd_chk(8'h00, j ? 16'h0800 : 16'h8000);
      pin(1'b0);
      host.wr(8'h00, 16'h0000);
      rd_chk(8'h00, 16'h0000);
    end
    stop_test();
  end
endmodule // testbench
